// File: rtl/zqc_calibration_control.sv
// zq calibration control: long and short calibration sequencing in the device
// assumes commands arrive decoded on core_clk_i; the comparator comes from the
// analog calibration engine and is asynchronous, so it is synchronised here
//
// What this block and the controller must do
// RULE1 - long calibration command starts full driver and termination calibration
// RULE2 - calibrated result is copied to driver and termination codes at the io
// RULE3 - first long calibration after reset uses the initial period
// RULE4 - later long calibrations use the shorter operational period
// RULE5 - short calibration corrects drift and completes within its own period
// RULE6 - one short calibration steps codes at least one unit within 64 clocks
// RULE7 - controller spaces short calibrations by correction over total drift
// RULE8 - controller keeps the channel quiet during any calibration window
// RULE9 - calibration current path is switched off once calibration finishes
// RULE10 - controller precharges all banks and meets precharge time first
// RULE11 - calibration commands are accepted while the dll is still locking
// RULE12 - self refresh exit never starts a calibration by itself
// RULE13 - controller waits the self refresh exit time before calibrating
// RULE14 - controller keeps windows of devices sharing a resistor apart
// RULE15 - controller holds clock enable high during the whole calibration
// RULE16 - termination is forced off while calibration runs
// RULE17 - every device on the data bus stays high impedance meanwhile
// RULE18 - a reset-cleared flag, set by first long calibration, picks the period
`timescale 1ns/1ps

module zqc_calibration_control
   import zqc_pkg::*;
#(
   parameter int INIT_NCK = `ZQC_INIT_NCK,
   parameter int OPER_NCK = `ZQC_OPER_NCK,
   parameter int CS_NCK   = `ZQC_CS_NCK
) (
   // clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             reset_i,
   input  wire logic             clk_en_i,
   // decoded commands
   input  wire logic             cal_long_i,
   input  wire logic             cal_short_i,
   input  wire logic             self_refresh_exit_i,
   input  wire logic             dll_locking_i,
   // termination request from the odt logic
   input  wire logic             odt_req_i,
   // analog calibration engine
   input  wire logic             cmp_high_i,
   // io codes and status
   output logic [`ZQC_CODE_W-1:0] drv_code_o,
   output logic [`ZQC_CODE_W-1:0] odt_code_o,
   output logic                   odt_en_o,
   output logic                   zq_current_en_o,
   output logic                   cal_busy_o,
   output logic                   cal_done_o,
   output logic                   init_done_o,
   output logic                   cmd_accept_o
);

   ////////////////////////////////////////////////////////////////////////////
   // constants

   localparam zqc_cnt_t INIT_CNT = zqc_cnt_t'(INIT_NCK);
   localparam zqc_cnt_t OPER_CNT = zqc_cnt_t'(OPER_NCK);
   localparam zqc_cnt_t CS_CNT   = zqc_cnt_t'(CS_NCK);
   localparam zqc_cnt_t XFER_CNT = zqc_cnt_t'(`ZQC_XFER_NCK);
   // stepping period keeps at least one step inside any 64-clock span
   localparam zqc_cnt_t STEP_CNT = zqc_cnt_t'(`ZQC_CS_CORRECT_NCK / 2);

   ////////////////////////////////////////////////////////////////////////////
   // comparator synchroniser

   logic cmp_meta;
   logic cmp_sync;

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cmp_meta <= 1'b0;
         cmp_sync <= 1'b0;
      end else if (clk_en_i) begin
         cmp_meta <= cmp_high_i;
         cmp_sync <= cmp_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command acceptance

   zqc_state_e state;
   zqc_cnt_t   win_cnt;
   zqc_cnt_t   step_cnt;
   zqc_code_t  eng_code;
   logic       long_cal;
   logic       init_done;
   logic       start_long;
   logic       start_short;

   // dll lock state deliberately does not gate acceptance
   assign cmd_accept_o = (state == ZQC_IDLE);                          // RULE11
   assign start_long   = cmd_accept_o && cal_long_i;                   // RULE1
   assign start_short  = cmd_accept_o && cal_short_i && !cal_long_i;   // RULE5
   // self_refresh_exit_i and dll_locking_i never start anything
   logic unused_ok;
   assign unused_ok = self_refresh_exit_i ^ dll_locking_i;             // RULE12

   ////////////////////////////////////////////////////////////////////////////
   // first-long flag

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         init_done <= 1'b0;                                             // RULE18
      end else if (clk_en_i && start_long) begin
         init_done <= 1'b1;                                             // RULE18
      end
   end

   assign init_done_o = init_done;

   ////////////////////////////////////////////////////////////////////////////
   // sequencer

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state    <= ZQC_IDLE;
         win_cnt  <= `ZQC_CNT_ZERO;
         long_cal <= 1'b0;
      end else if (clk_en_i) begin
         unique case (state)
            ZQC_IDLE: begin
               if (start_long) begin
                  state    <= ZQC_CAL;
                  long_cal <= 1'b1;
                  win_cnt  <= init_done ? OPER_CNT : INIT_CNT;           // RULE3 RULE4
               end else if (start_short) begin
                  state    <= ZQC_CAL;
                  long_cal <= 1'b0;
                  win_cnt  <= CS_CNT;                                    // RULE5
               end
            end
            ZQC_CAL: begin
               win_cnt <= win_cnt - `ZQC_CNT_ONE;
               // leave room for the transfer inside the window
               if (win_cnt <= XFER_CNT + `ZQC_CNT_ONE) begin
                  state <= ZQC_XFER;
               end
            end
            ZQC_XFER: begin
               win_cnt <= win_cnt - `ZQC_CNT_ONE;
               state   <= ZQC_QUIET;
            end
            ZQC_QUIET: begin
               if (win_cnt <= `ZQC_CNT_ONE) begin
                  state   <= ZQC_IDLE;
                  win_cnt <= `ZQC_CNT_ZERO;
               end else begin
                  win_cnt <= win_cnt - `ZQC_CNT_ONE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // calibration engine: successive single-step tracking

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         eng_code <= `ZQC_CODE_RESET;
         step_cnt <= `ZQC_CNT_ZERO;
      end else if (clk_en_i) begin
         if (state != ZQC_CAL || step_cnt >= STEP_CNT - `ZQC_CNT_ONE) begin
            step_cnt <= `ZQC_CNT_ZERO;
         end else begin
            step_cnt <= step_cnt + `ZQC_CNT_ONE;
         end
         // step on the first cal cycle, so even a short window moves the code;
         // long calibration steps every cycle for full range
         if (state == ZQC_CAL && (step_cnt == `ZQC_CNT_ZERO || long_cal)) begin
            if (cmp_sync && eng_code != '1) begin
               eng_code <= eng_code + `ZQC_CODE_ONE;                   // RULE6
            end else if (!cmp_sync && eng_code != '0) begin
               eng_code <= eng_code - `ZQC_CODE_ONE;                   // RULE6
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transfer to io and outputs

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         drv_code_o <= `ZQC_CODE_RESET;
         odt_code_o <= `ZQC_CODE_RESET;
      end else if (clk_en_i && state == ZQC_XFER) begin
         // io codes change only here, so drivers never see a walking code
         drv_code_o <= eng_code;                                        // RULE2
         odt_code_o <= eng_code;                                        // RULE2
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cal_done_o <= 1'b0;
      end else if (clk_en_i) begin
         cal_done_o <= (state == ZQC_QUIET) && (win_cnt <= `ZQC_CNT_ONE);
      end
   end

   assign cal_busy_o      = (state != ZQC_IDLE);
   // current path only while the engine compares
   assign zq_current_en_o = (state == ZQC_CAL);                         // RULE9
   // termination is dropped even if the controller left it on
   assign odt_en_o        = odt_req_i && (state == ZQC_IDLE);           // RULE16

endmodule // zqc_calibration_control

// File: common/zqc_map.svh
// zq calibration control: timing and code constants
// assumes a 200 MHz core clock; included by the package, and the design uses its macros
`ifndef ZQC_MAP_SVH
`define ZQC_MAP_SVH

`define ZQC_CLK_PERIOD_PS    5000
// calibration windows, in clock periods of the dram clock
`define ZQC_INIT_NCK         1024
`define ZQC_OPER_NCK         512
`define ZQC_CS_NCK           128
// a short calibration corrects within this many clocks
`define ZQC_CS_CORRECT_NCK   64
// cycles kept at the end of the window for the move to the io and the quiet cycle after it
`define ZQC_XFER_NCK         2
`define ZQC_CODE_W           6
`define ZQC_CODE_RESET       6'h20
`define ZQC_CNT_W            11
`define ZQC_CNT_ONE          11'h001
`define ZQC_CNT_ZERO         11'h000
`define ZQC_CODE_ONE         6'h01

`endif

// File: common/zqc_pkg.sv
// zq calibration control: shared types
// assumes zqc_map.svh sits on the include path
`include "zqc_map.svh"

package zqc_pkg;

   typedef enum logic [1:0] {
      ZQC_IDLE,
      ZQC_CAL,
      ZQC_XFER,
      ZQC_QUIET
   } zqc_state_e;

   typedef logic [`ZQC_CODE_W-1:0] zqc_code_t;
   typedef logic [`ZQC_CNT_W-1:0]  zqc_cnt_t;

endpackage

// File: tb/zqc_chk.sv
// zq calibration checker: window lengths and status relations
// assumes clk_en_i stays high while a window runs
`timescale 1ns/1ps
module zqc_chk
   import zqc_pkg::*;
#(parameter int INIT_NCK = 1024, parameter int OPER_NCK = 512, parameter int CS_NCK = 128) (
   input wire logic core_clk_i, reset_i, clk_en_i, cal_long_i, cal_short_i,
   input wire logic self_refresh_exit_i, odt_en_o, zq_current_en_o, cal_busy_o,
   input wire logic cal_done_o, init_done_o, cmd_accept_o,
   input wire zqc_code_t drv_code_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   int cnt;
   int win;
   wire take = clk_en_i && cmd_accept_o && (cal_long_i || cal_short_i);
   // window expected from the kind taken and the flag at that moment
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt <= 0;
         win <= 0;
      end else begin
         cnt <= take ? 0 : cnt + (cal_busy_o ? 1 : 0);
         if (take) win <= cal_long_i ? (init_done_o ? OPER_NCK : INIT_NCK) : CS_NCK;
      end
   end
   sequence s_take; take; endsequence
   sequence s_end; !cal_busy_o && $past(cal_busy_o); endsequence
   a_busy_after_take: assert property (s_take |=> cal_busy_o)
      else $error("busy missing after command");
   a_window_len: assert property ($fell(cal_busy_o) |-> cnt == win)
      else $error("window length wrong");
   a_done_ends_busy: assert property (cal_done_o |-> s_end)
      else $error("done out of place");
   a_init_flag_set: assert property (s_take and cal_long_i |=> init_done_o)
      else $error("init flag not set");
   a_odt_off_busy: assert property (cal_busy_o |-> !odt_en_o)
      else $error("termination on while busy");
   a_current_off_idle: assert property (!cal_busy_o |-> !zq_current_en_o)
      else $error("current path on while idle");
   a_busy_refuses: assert property (cal_busy_o |-> !cmd_accept_o)
      else $error("accepting while busy");
   a_codes_hold_idle: assert property (!cal_busy_o |=> $stable(drv_code_o))
      else $error("codes moved while idle");
   a_srx_no_cal: assert property (self_refresh_exit_i && !take && !cal_busy_o |=> !cal_busy_o)
      else $error("self refresh exit started calibration");
endmodule // zqc_chk

bind zqc_calibration_control zqc_chk #(.INIT_NCK(INIT_NCK), .OPER_NCK(OPER_NCK),
   .CS_NCK(CS_NCK)) u_chk (.core_clk_i(core_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
   .cal_long_i(cal_long_i), .cal_short_i(cal_short_i), .self_refresh_exit_i(self_refresh_exit_i),
   .odt_en_o(odt_en_o), .zq_current_en_o(zq_current_en_o), .cal_busy_o(cal_busy_o),
   .cal_done_o(cal_done_o), .init_done_o(init_done_o), .cmd_accept_o(cmd_accept_o),
   .drv_code_o(drv_code_o));

// File: tb/zqc_ctrl_model.sv
// controller-side model: forwards calibration commands, holds clock enable
// assumes requests come only with banks precharged and the channel idle
`timescale 1ns/1ps
module zqc_ctrl_model (
   input  wire logic req_long_i, req_short_i, srx_i,
   output logic      cal_long_o, cal_short_o, clk_en_o, self_refresh_exit_o
);
   assign clk_en_o = 1'b1;
   // no other traffic is modelled, so every window stays quiet
   assign cal_long_o = req_long_i;
   assign cal_short_o = req_short_i;
   assign self_refresh_exit_o = srx_i;
endmodule // zqc_ctrl_model

// File: tb/tb.sv
// testbench: long, short, refused and self refresh exit scenarios
// assumes shortened windows 64/32/16 and a 200 MHz clock
`timescale 1ns/1ps
module tb;
   import zqc_pkg::*;
   logic      clk = 0, rst = 1, rl = 0, rs = 0, srx = 0, dll = 0, odt = 1, cmp = 1;
   logic      cl, cs, ce, sx, oen, cur, busy, done, initd, acc;
   zqc_code_t drv, odc;
   int        num_errors = 0, num_checks = 0;
   zqc_calibration_control #(.INIT_NCK(64), .OPER_NCK(32), .CS_NCK(16)) dut (
      .core_clk_i(clk), .reset_i(rst), .clk_en_i(ce), .cal_long_i(cl), .cal_short_i(cs),
      .self_refresh_exit_i(sx), .dll_locking_i(dll), .odt_req_i(odt), .cmp_high_i(cmp),
      .drv_code_o(drv), .odt_code_o(odc), .odt_en_o(oen), .zq_current_en_o(cur),
      .cal_busy_o(busy), .cal_done_o(done), .init_done_o(initd), .cmd_accept_o(acc));
   zqc_ctrl_model u_ctrl (.req_long_i(rl), .req_short_i(rs), .srx_i(srx),
      .cal_long_o(cl), .cal_short_o(cs), .clk_en_o(ce), .self_refresh_exit_o(sx));
   initial forever #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: %s", $time, m);
      end
   endtask
   task automatic results;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // poke sends a short command mid-window, which must be ignored
   task automatic run_cal(input bit lng, input int n, input bit poke);
      int c;
      c = 0;
      @(posedge clk);
      rl <= lng;
      rs <= !lng;
      @(posedge clk);
      rl <= 0;
      rs <= 0;
      #1 chk(cur, 1, "current path");
      chk(oen, 0, "termination");
      while (busy === 1'b1 && c < 2000) begin
         @(posedge clk);
         rs <= poke && c == 2;
         #1 c++;
      end
      chk(c, n, "window");
      chk(done, 1, "done");
      chk(cur, 0, "current off");
      chk(oen, 1, "termination back");
   endtask
   task automatic t_long;
      run_cal(1, 64, 0);
      chk(initd, 1, "init flag");
      chk(drv > 6'h20, 1, "driver code");
      chk(odc > 6'h20, 1, "termination code");
      dll <= 1;
      run_cal(1, 32, 1);
      $display("long tests done");
   endtask
   task automatic t_srx;
      @(posedge clk);
      srx <= 1;
      cmp <= 0;
      repeat (4) @(posedge clk);
      srx <= 0;
      #1 chk(busy, 0, "no self calibration");
      run_cal(0, 16, 0);
      chk(drv < 6'h3f, 1, "short step");
      $display("self refresh test done");
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst <= 0;
      #1 chk(drv, 6'h20, "driver reset");
      chk(initd, 0, "flag reset");
      chk(acc, 1, "accept idle");
      $display("reset test done");
      t_long;
      t_srx;
      results;
   end
   initial begin
      #5000;
      num_errors++;
      results;
   end
endmodule // tb
